// [inc/dacc_pkg.sv]
/*
  Constants for the eight-channel audio converter mode-control block.
  Assumes 16-bit control words arrive already framed from the serial port.
*/
`default_nettype none
package dacc_pkg;
  // Control word layout.
  localparam int WORD_MARK_BIT = 15;
  localparam int INDEX_MSB     = 14;
  localparam int INDEX_LSB     = 8;
  localparam int DATA_MSB      = 7;
  // Register indices.
  localparam logic [6:0] REG_GAIN_CH1  = 7'h01;
  localparam logic [6:0] REG_GAIN_CH6  = 7'h06;
  localparam logic [6:0] REG_SILENCE   = 7'h07;
  localparam logic [6:0] REG_DISABLE   = 7'h08;
  localparam logic [6:0] REG_FILT_FORM = 7'h09;
  localparam logic [6:0] REG_RST_POL   = 7'h0A;
  localparam logic [6:0] REG_STEP_MODE = 7'h0D;
  localparam logic [6:0] REG_GAIN_CH7  = 7'h10;
  localparam logic [6:0] REG_GAIN_CH8  = 7'h11;
  localparam logic [6:0] REG_SIL_ALIAS = 7'h12;
  localparam logic [6:0] REG_DIS_ALIAS = 7'h13;
  // Field positions.
  localparam int ROLLOFF_BIT    = 5;
  localparam int FORMAT_MSB     = 3;
  localparam int SOFT_RESET_BIT = 7;
  localparam int ZERO_POL_BIT   = 6;
  localparam int PHASE_BIT      = 5;
  localparam int DEEMPH_MSB     = 4;
  localparam int DEEMPH_LSB     = 3;
  localparam int DEEMPH_EN_BIT  = 0;
  localparam int STEP_MODE_BIT  = 7;
  // Reset values.
  localparam logic [7:0] GAIN_RESET    = 8'hFF;
  localparam logic [3:0] FORMAT_RESET  = 4'h5;
  localparam logic [1:0] DEEMPH_RESET  = 2'h0;
  // Level thresholds: codes at or below these are infinite attenuation.
  localparam logic [7:0] SILENT_FINE   = 8'h80;
  localparam logic [7:0] SILENT_WIDE   = 8'h9A;
  localparam logic [7:0] ATTEN_INF     = 8'hFF;
  // Timing counts.
  localparam int FS_PER_STEP       = 8;
  localparam int SOFT_RESET_CLOCKS = 1024;
endpackage
`default_nettype wire

// [rtl/dacc_ramp.sv]
/*
  One channel's attenuator: walks the applied level toward its goal.
  Assumes step_i pulses once every eight sampling periods.
*/
`timescale 1ns/100ps
`default_nettype none
module dacc_ramp (
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  // Control.
  input  wire logic       step_i,
  input  wire logic       wide_mode_i,
  input  wire logic       silence_i,
  input  wire logic [7:0] target_i,
  // Applied state.
  output logic      [7:0] level_o,
  output logic      [7:0] atten_o,
  output logic            silent_o
);
  logic [7:0] thr;
  logic [7:0] goal;
  logic [7:0] drop;

  // Goal is the programmed code, or the silent floor when muted or when the code is below it.
  always_comb begin
    thr  = wide_mode_i ? dacc_pkg::SILENT_WIDE : dacc_pkg::SILENT_FINE;
    goal = (silence_i || target_i < thr) ? thr : target_i;
    drop = dacc_pkg::GAIN_RESET - level_o;
  end

  // One code step per tick; only a hardware reset or a soft reset clear jumps, straight to code 255.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 8'hFF;
    end else if (clear_i) begin
      level_o <= dacc_pkg::GAIN_RESET;
    end else if (step_i && level_o < goal) begin
      level_o <= level_o + 8'h01;
    end else if (step_i && level_o > goal) begin
      level_o <= level_o - 8'h01;
    end
  end

  // Attenuation in half-dB units; all ones means infinite.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atten_o  <= 8'h00;
      silent_o <= 1'b0;
    end else begin
      silent_o <= (level_o <= thr);
      if (level_o <= thr) begin
        atten_o <= dacc_pkg::ATTEN_INF;
      end else if (wide_mode_i) begin
        atten_o <= {drop[6:0], 1'b0};
      end else begin
        atten_o <= drop;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/dacc_mode_ctrl.sv]
/*
  Mode-control register bank of an eight-channel audio converter.
  Holds the per-channel attenuation, soft mute and output disable, the
  filter, format, phase, zero-flag and de-emphasis settings, and a soft
  reset sequencer. Control words arrive already framed as 16-bit words
  from the serial control port; fs_tick_i pulses once per sampling
  period, synchronous to clock_i.
*/
// How it works
// - Attenuation equals step size times code minus 255; reset code 255 is 0 dB.
// - Mode bit clear gives 0.5 dB steps to -63; set gives 1 dB to -100.
// - Codes up to 128 fine, or up to 154 wide, silence the channel.
// - Applied level moves one step per eight sampling periods toward target.
// - Each of eight channels keeps its own code; writes touch one only.
// - Mute ramps down to silence stepwise; unmute ramps back to target.
// - Channels seven and eight mute when either mute copy is set.
// - Disable bit feeds the output amplifier from common-mode; clear at reset.
// - Channels seven and eight disable when either disable copy is set.
// - Roll-off bit selects sharp at 0, the reset value, slow at 1.
// - Four-bit format field selects audio format; resets to left-justified.
// - Soft reset bit reinitialises all registers for 1024 system clocks.
// - Zero-flag polarity 0 drives flags high on zero, 1 drives low.
// - Phase bit 0 is normal, 1 inverts all outputs; resets to 0.
// - De-emphasis rate 00 is 44.1 kHz, 01 48 kHz, 10 32 kHz.
// - Every mute bit is zero after reset.
// - De-emphasis enable turns it on for all channels; clear at reset.
`timescale 1ns/100ps
`default_nettype none
module dacc_mode_ctrl #(
  parameter int CHANNELS     = 8,
  parameter int RESET_CLOCKS = dacc_pkg::SOFT_RESET_CLOCKS,
  parameter int STEP_PERIODS = dacc_pkg::FS_PER_STEP
) (
  // Clock and reset.
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // Framed control words from the serial port.
  input  wire logic                  word_valid_i,
  input  wire logic [15:0]           word_i,
  // Sampling-rate strobe.
  input  wire logic                  fs_tick_i,
  // Raw zero detection from the audio path.
  input  wire logic [1:0]            zero_detect_i,
  // Per-channel attenuator state, mute and output disable.
  output logic [8*CHANNELS-1:0]      channel_gain_code_o,
  output logic [8*CHANNELS-1:0]      channel_atten_o,
  output logic [CHANNELS-1:0]        channel_silent_o,
  output logic [CHANNELS-1:0]        channel_soft_silence_o,
  output logic [CHANNELS-1:0]        channel_output_disable_o,
  // Global settings.
  output logic                       gain_step_mode_o,
  output logic                       rolloff_select_o,
  output logic [3:0]                 audio_format_select_o,
  output logic                       global_phase_invert_o,
  output logic [1:0]                 deemphasis_rate_select_o,
  output logic                       deemphasis_all_enable_o,
  // Zero flags and reset status.
  output logic [1:0]                 zero_flag_o,
  output logic                       soft_reset_active_o
);
  localparam int RCW = $clog2(RESET_CLOCKS);
  localparam int SCW = $clog2(STEP_PERIODS);
  localparam logic [RCW-1:0] RESET_LAST = RCW'(RESET_CLOCKS - 1);
  localparam logic [SCW-1:0] STEP_LAST  = SCW'(STEP_PERIODS - 1);

  typedef enum logic [1:0] {
    DACC_RUN   = 2'b01,
    DACC_CLEAR = 2'b10
  } dacc_state_t;

  // Maps a register index to a gain channel; returns CHANNELS if none.
  function automatic int gain_channel(input logic [6:0] reg_sel);
    int ch;
    ch = CHANNELS;
    if (reg_sel >= dacc_pkg::REG_GAIN_CH1 && reg_sel <= dacc_pkg::REG_GAIN_CH6) begin
      ch = int'(reg_sel) - 1;
    end else if (reg_sel == dacc_pkg::REG_GAIN_CH7) begin
      ch = 6;
    end else if (reg_sel == dacc_pkg::REG_GAIN_CH8) begin
      ch = 7;
    end
    return ch;
  endfunction

  dacc_state_t     state_r;
  dacc_state_t     state_nxt;
  logic [RCW-1:0]  reset_count_r;
  logic [SCW-1:0]  fs_count_r;
  logic            step_r;
  logic            clear;
  logic            wr;
  logic [6:0]      wr_index;
  logic [7:0]      wr_data;
  logic [7:0]      gain_code_r [CHANNELS];
  logic [7:0]      silence_r;
  logic [1:0]      silence_alias_r;
  logic [7:0]      disable_r;
  logic [1:0]      disable_alias_r;
  logic            rolloff_r;
  logic [3:0]      format_r;
  logic            zero_pol_r;
  logic            phase_r;
  logic [1:0]      deemph_rate_r;
  logic            deemph_en_r;
  logic            step_mode_r;
  logic [7:0]      silence_eff;
  logic [7:0]      disable_eff;

  // Word decode: a word with bit 15 set is not a register write.
  always_comb begin
    wr       = word_valid_i && !word_i[dacc_pkg::WORD_MARK_BIT];
    wr_index = word_i[dacc_pkg::INDEX_MSB:dacc_pkg::INDEX_LSB];
    wr_data  = word_i[dacc_pkg::DATA_MSB:0];
    clear    = (state_r == DACC_CLEAR);
  end

  // Soft reset sequencer next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DACC_RUN: begin
        if (wr && wr_index == dacc_pkg::REG_RST_POL &&
            wr_data[dacc_pkg::SOFT_RESET_BIT]) begin
          state_nxt = DACC_CLEAR;
        end
      end
      DACC_CLEAR: begin
        if (reset_count_r == RESET_LAST) begin
          state_nxt = DACC_RUN;
        end
      end
      default: begin
        state_nxt = DACC_RUN;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= DACC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counts the soft reset period in system clocks.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_count_r <= '0;
    end else if (clear) begin
      reset_count_r <= reset_count_r + RCW'(1);
    end else begin
      reset_count_r <= '0;
    end
  end

  // Divides the sampling strobe down to one ramp step per eight periods.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_count_r <= '0;
      step_r     <= 1'b0;
    end else if (clear) begin
      fs_count_r <= '0;
      step_r     <= 1'b0;
    end else begin
      step_r <= fs_tick_i && (fs_count_r == STEP_LAST);
      if (fs_tick_i) begin
        fs_count_r <= fs_count_r + SCW'(1);
      end
    end
  end

  // Per-channel gain codes; a write changes only the addressed channel.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        gain_code_r[i] <= dacc_pkg::GAIN_RESET;
      end
    end else if (clear) begin
      for (int i = 0; i < CHANNELS; i++) begin
        gain_code_r[i] <= dacc_pkg::GAIN_RESET;
      end
    end else if (wr && gain_channel(wr_index) < CHANNELS) begin
      gain_code_r[gain_channel(wr_index)] <= wr_data;
    end
  end

  // Soft mute bits and their channel seven and eight copies.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      silence_r       <= 8'h00;
      silence_alias_r <= 2'h0;
    end else if (clear) begin
      silence_r       <= 8'h00;
      silence_alias_r <= 2'h0;
    end else if (wr && wr_index == dacc_pkg::REG_SILENCE) begin
      silence_r <= wr_data;
    end else if (wr && wr_index == dacc_pkg::REG_SIL_ALIAS) begin
      silence_alias_r <= wr_data[1:0];
    end
  end

  // Output disable bits and their channel seven and eight copies.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disable_r       <= 8'h00;
      disable_alias_r <= 2'h0;
    end else if (clear) begin
      disable_r       <= 8'h00;
      disable_alias_r <= 2'h0;
    end else if (wr && wr_index == dacc_pkg::REG_DISABLE) begin
      disable_r <= wr_data;
    end else if (wr && wr_index == dacc_pkg::REG_DIS_ALIAS) begin
      disable_alias_r <= wr_data[1:0];
    end
  end

  // Filter roll-off and audio format; reserved bits are not stored.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rolloff_r <= 1'b0;
      format_r  <= dacc_pkg::FORMAT_RESET;
    end else if (clear) begin
      rolloff_r <= 1'b0;
      format_r  <= dacc_pkg::FORMAT_RESET;
    end else if (wr && wr_index == dacc_pkg::REG_FILT_FORM) begin
      rolloff_r <= wr_data[dacc_pkg::ROLLOFF_BIT];
      format_r  <= wr_data[dacc_pkg::FORMAT_MSB:0];
    end
  end

  // Zero-flag polarity, phase and de-emphasis settings.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_pol_r    <= 1'b0;
      phase_r       <= 1'b0;
      deemph_rate_r <= dacc_pkg::DEEMPH_RESET;
      deemph_en_r   <= 1'b0;
    end else if (clear) begin
      zero_pol_r    <= 1'b0;
      phase_r       <= 1'b0;
      deemph_rate_r <= dacc_pkg::DEEMPH_RESET;
      deemph_en_r   <= 1'b0;
    end else if (wr && wr_index == dacc_pkg::REG_RST_POL) begin
      zero_pol_r    <= wr_data[dacc_pkg::ZERO_POL_BIT];
      phase_r       <= wr_data[dacc_pkg::PHASE_BIT];
      deemph_rate_r <= wr_data[dacc_pkg::DEEMPH_MSB:dacc_pkg::DEEMPH_LSB];
      deemph_en_r   <= wr_data[dacc_pkg::DEEMPH_EN_BIT];
    end
  end

  // Attenuation step mode.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_mode_r <= 1'b0;
    end else if (clear) begin
      step_mode_r <= 1'b0;
    end else if (wr && wr_index == dacc_pkg::REG_STEP_MODE) begin
      step_mode_r <= wr_data[dacc_pkg::STEP_MODE_BIT];
    end
  end

  // Channels seven and eight take either copy of mute and disable.
  always_comb begin
    silence_eff      = silence_r;
    silence_eff[7:6] = silence_r[7:6] | silence_alias_r;
    disable_eff      = disable_r;
    disable_eff[7:6] = disable_r[7:6] | disable_alias_r;
  end

  // One attenuator per channel.
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ramp
    dacc_ramp u_ramp (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .clear_i     (clear),
      .step_i      (step_r),
      .wide_mode_i (step_mode_r),
      .silence_i   (silence_eff[c]),
      .target_i    (gain_code_r[c]),
      .level_o     (channel_gain_code_o[8*c +: 8]),
      .atten_o     (channel_atten_o[8*c +: 8]),
      .silent_o    (channel_silent_o[c])
    );
  end

  // Settings presented to the datapath, all from flip-flops.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_soft_silence_o   <= '0;
      channel_output_disable_o <= '0;
      gain_step_mode_o         <= 1'b0;
      rolloff_select_o         <= 1'b0;
      audio_format_select_o    <= dacc_pkg::FORMAT_RESET;
      global_phase_invert_o    <= 1'b0;
      deemphasis_rate_select_o <= dacc_pkg::DEEMPH_RESET;
      deemphasis_all_enable_o  <= 1'b0;
      zero_flag_o              <= 2'h0;
      soft_reset_active_o      <= 1'b0;
    end else begin
      channel_soft_silence_o   <= silence_eff[CHANNELS-1:0];
      channel_output_disable_o <= disable_eff[CHANNELS-1:0];
      gain_step_mode_o         <= step_mode_r;
      rolloff_select_o         <= rolloff_r;
      audio_format_select_o    <= format_r;
      global_phase_invert_o    <= phase_r;
      deemphasis_rate_select_o <= deemph_rate_r;
      deemphasis_all_enable_o  <= deemph_en_r;
      zero_flag_o              <= zero_detect_i ^ {2{zero_pol_r}};
      soft_reset_active_o      <= clear;
    end
  end
endmodule
`default_nettype wire

// [tb/dacc_host.sv]
/*
  Host model: frames control words and makes the sampling strobe.
  Assumes the bench calls send from its main sequence.
*/
`timescale 1ns/100ps
`default_nettype none
module dacc_host (
  // Clock.
  input  wire logic        clock_i,
  // Words and strobe.
  output logic             word_valid_o,
  output logic      [15:0] word_o,
  output logic             fs_tick_o
);
  logic [1:0] div_r = 2'h0;

  // Idle values at time zero.
  initial begin
    word_valid_o = 1'b0;
    word_o = 16'h0000;
    fs_tick_o = 1'b0;
  end

  // One sampling strobe every four clocks.
  always @(posedge clock_i) begin
    div_r <= div_r + 2'h1;
    fs_tick_o <= #1 (div_r == 2'h3);
  end

  // Holds a word for one edge, then scrambles the released bus.
  task automatic send(input logic [15:0] w);
    @(posedge clock_i);
    #1 word_valid_o = 1'b1;
    word_o = w;
    @(posedge clock_i);
    #1 word_valid_o = 1'b0;
    word_o = ~w;
  endtask
endmodule
`default_nettype wire

// [tb/dacc_mode_chk.sv]
/*
  Checker for the mode-control bank, watching channel one's attenuator.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module dacc_mode_chk #(
  parameter int CHANNELS     = 8,
  parameter int RESET_CLOCKS = 1024
) (
  // Clock, reset and inputs.
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  word_valid_i,
  input  wire logic [15:0]           word_i,
  input  wire logic [1:0]            zero_detect_i,
  // Outputs watched.
  input  wire logic [8*CHANNELS-1:0] channel_gain_code_o,
  input  wire logic [8*CHANNELS-1:0] channel_atten_o,
  input  wire logic [CHANNELS-1:0]   channel_silent_o,
  input  wire logic [CHANNELS-1:0]   channel_soft_silence_o,
  input  wire logic [CHANNELS-1:0]   channel_output_disable_o,
  input  wire logic                  gain_step_mode_o,
  input  wire logic                  rolloff_select_o,
  input  wire logic [3:0]            audio_format_select_o,
  input  wire logic [1:0]            zero_flag_o,
  input  wire logic                  soft_reset_active_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] code0;
  int         act_cnt_r;

  // Channel one's applied code.
  assign code0 = channel_gain_code_o[7:0];

  // Counts the cycles of one soft reset period.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_cnt_r <= 0;
    end else begin
      act_cnt_r <= soft_reset_active_o ? act_cnt_r + 1 : 0;
    end
  end

  // Expected attenuation in half-decibel units for a code.
  function automatic logic [7:0] atten_of(input logic m, input logic [7:0] c);
    if (m) return (c <= 8'h9A) ? 8'hFF : 8'((8'hFF - c) << 1);
    return (c <= 8'h80) ? 8'hFF : 8'hFF - c;
  endfunction

  zero_pol_a: assert property ($past(rst_n_i) |->
    (zero_flag_o ^ $past(zero_detect_i)) inside {2'h0, 2'h3})
    else $error("zero flag polarity mismatch");
  step_gap_a: assert property ($changed(code0) |=>
    (soft_reset_active_o || $stable(code0)) [*7])
    else $error("attenuator stepped too soon");
  step_size_a: assert property ($changed(code0) && code0 != 8'hFF |->
    (8'(code0 - $past(code0))) inside {8'h01, 8'hFF}) else $error("step not one code");
  atten_map_a: assert property ($past(gain_step_mode_o, 2) == gain_step_mode_o &&
    $past(gain_step_mode_o) == gain_step_mode_o && code0 != 8'hFF
    |-> channel_atten_o[7:0] == atten_of(gain_step_mode_o, $past(code0)))
    else $error("attenuation does not match code");
  silent_sync_a: assert property (channel_silent_o[0] == (channel_atten_o[7:0] == 8'hFF))
    else $error("silent flag disagrees with attenuation");
  reset_len_a: assert property ($fell(soft_reset_active_o) |-> act_cnt_r == RESET_CLOCKS)
    else $error("soft reset length wrong");
  reset_clear_a: assert property (soft_reset_active_o && $past(soft_reset_active_o) |->
    audio_format_select_o == 4'h5 && !rolloff_select_o && channel_soft_silence_o == '0 &&
    channel_output_disable_o == '0 && code0 == 8'hFF) else $error("soft reset left state behind");
  rolloff_wr_a: assert property (word_valid_i && word_i[15:8] == 8'h09 && !soft_reset_active_o
    |-> ##2 rolloff_select_o == $past(word_i[5], 2) &&
    audio_format_select_o == $past(word_i[3:0], 2)) else $error("filter write lost");
  mute_low_a: assert property (word_valid_i && word_i[15:8] == 8'h07 && !soft_reset_active_o
    |-> ##2 channel_soft_silence_o[5:0] == $past(word_i[5:0], 2)) else $error("mute write lost");
  mute_or_a: assert property (word_valid_i && word_i[15:8] == 8'h12 && word_i[0]
    |-> ##2 channel_soft_silence_o[6]) else $error("mute copy ignored");
  dis_low_a: assert property (word_valid_i && word_i[15:8] == 8'h08 && !soft_reset_active_o
    |-> ##2 channel_output_disable_o[5:0] == $past(word_i[5:0], 2)) else $error("disable lost");
  dis_or_a: assert property (word_valid_i && word_i[15:8] == 8'h13 && word_i[1]
    |-> ##2 channel_output_disable_o[7]) else $error("disable copy ignored");
  mark_bit_a: assert property (word_valid_i && word_i[15]
    |-> ##2 $stable(audio_format_select_o)) else $error("marked word was taken");

  cover property ($rose(soft_reset_active_o));
  cover property ($rose(channel_silent_o[0]));
  cover property ($changed(code0) && gain_step_mode_o);
endmodule

bind dacc_mode_ctrl dacc_mode_chk #(.CHANNELS(CHANNELS), .RESET_CLOCKS(RESET_CLOCKS)) chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .word_valid_i(word_valid_i), .word_i(word_i),
  .zero_detect_i(zero_detect_i), .channel_gain_code_o(channel_gain_code_o),
  .channel_atten_o(channel_atten_o), .channel_silent_o(channel_silent_o),
  .channel_soft_silence_o(channel_soft_silence_o),
  .channel_output_disable_o(channel_output_disable_o), .gain_step_mode_o(gain_step_mode_o),
  .rolloff_select_o(rolloff_select_o), .audio_format_select_o(audio_format_select_o),
  .zero_flag_o(zero_flag_o), .soft_reset_active_o(soft_reset_active_o));
`default_nettype wire

// [tb/test_audio_dac_channel_control.sv]
/*
  Bench for the mode-control bank: writes control words, checks outputs.
  Assumes a short soft reset period of 16 clocks for run time.
*/
`timescale 1ns/100ps
`default_nettype none
module test_audio_dac_channel_control;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        word_valid_i, fs_tick_i, mode_o, roll_o, phase_o, demen_o, sreset_o;
  logic [15:0] word_i;
  logic [1:0]  zero_detect_i = 2'h1;
  logic [1:0]  rate_o, zf_o;
  logic [3:0]  form_o;
  logic [63:0] code_o, atten_o;
  logic [7:0]  silent_o, mute_o, dis_o;
  logic [3:0]  fmts [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'h5};
  int          mismatches = 0;
  int          checks = 0;
  int          cyc;

  // Design, host model and clock.
  dacc_mode_ctrl #(.RESET_CLOCKS(16)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .fs_tick_i(fs_tick_i),
    .zero_detect_i(zero_detect_i), .channel_gain_code_o(code_o), .channel_atten_o(atten_o),
    .channel_silent_o(silent_o), .channel_soft_silence_o(mute_o),
    .channel_output_disable_o(dis_o), .gain_step_mode_o(mode_o), .rolloff_select_o(roll_o),
    .audio_format_select_o(form_o), .global_phase_invert_o(phase_o),
    .deemphasis_rate_select_o(rate_o), .deemphasis_all_enable_o(demen_o), .zero_flag_o(zf_o),
    .soft_reset_active_o(sreset_o));
  dacc_host host (.clock_i(clock_i), .word_valid_o(word_valid_i), .word_o(word_i),
    .fs_tick_o(fs_tick_i));
  always #25 clock_i = ~clock_i;

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Writes one register, then lets its output settle.
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    host.send({1'b0, i, d});
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  // Waits a bounded time for channel one's code to reach a value.
  task automatic wait_code(input logic [7:0] v, input int n);
    for (cyc = 0; cyc < n && code_o[7:0] !== v; cyc++) #50;
    if (cyc >= n) begin
      mismatches++;
      end_sim;
    end
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    #50;
    chk("format", 4'h5, form_o);
    chk("codes", {8{8'hFF}}, code_o);
    chk("mute", 8'h00, mute_o);
    chk("disable", 8'h00, dis_o);
    chk("flags", 6'h00, {mode_o, roll_o, phase_o, demen_o, rate_o});
    chk("zero flag", 2'h1, zf_o);
    $display("reset value test done");
    foreach (fmts[k]) begin
      wr(7'h09, {4'h2, fmts[k]});
      chk("format", fmts[k], form_o);
      chk("rolloff", 1'b1, roll_o);
    end
    wr(7'h09, 8'h05);
    chk("rolloff", 1'b0, roll_o);
    for (int r = 0; r < 3; r++) begin
      wr(7'h0A, {3'h3, r[1:0], 3'h1});
      chk("deemphasis rate", r[1:0], rate_o);
    end
    chk("phase", 1'b1, phase_o);
    chk("deemphasis enable", 1'b1, demen_o);
    chk("zero flag", 2'h2, zf_o);
    wr(7'h0A, 8'h00);
    host.send(16'h8903);
    host.send({1'b0, 7'h0B, 8'h03});
    repeat (2) @(posedge clock_i);
    #1;
    chk("format", 4'h5, form_o);
    $display("settings test done");
    wr(7'h12, 8'h01);
    chk("mute", 8'h40, mute_o);
    wr(7'h07, 8'h80);
    chk("mute", 8'hC0, mute_o);
    wr(7'h13, 8'h02);
    wr(7'h08, 8'h05);
    chk("disable", 8'h85, dis_o);
    $display("alias test done");
    wr(7'h01, 8'hFD);
    wait_code(8'hFE, 100);
    wait_code(8'hFD, 100);
    chk("step spacing", 32, cyc);
    wr(7'h03, 8'hFE);
    #3200;
    chk("ch1 code", 8'hFD, code_o[7:0]);
    chk("ch2 code", 8'hFF, code_o[15:8]);
    chk("ch3 code", 8'hFE, code_o[23:16]);
    chk("ch1 atten", 8'h02, atten_o[7:0]);
    wr(7'h07, 8'h01);
    chk("mute", 8'h41, mute_o);
    wait_code(8'h80, 4500);
    #100;
    chk("silent", 1'b1, silent_o[0]);
    #3200;
    chk("muted code", 8'h80, code_o[7:0]);
    wr(7'h07, 8'h00);
    wait_code(8'hFD, 4500);
    $display("ramp and mute test done");
    wr(7'h0D, 8'h80);
    chk("step mode", 1'b1, mode_o);
    wr(7'h01, 8'h9B);
    wait_code(8'h9B, 4000);
    #100;
    chk("wide atten", 8'hC8, atten_o[7:0]);
    chk("silent", 1'b0, silent_o[0]);
    wr(7'h01, 8'h9A);
    wait_code(8'h9A, 100);
    #100;
    chk("wide floor", 9'h1FF, {silent_o[0], atten_o[7:0]});
    $display("wide mode test done");
    wr(7'h0A, 8'h80);
    chk("reset active", 1'b1, sreset_o);
    host.send({1'b0, 7'h09, 8'h20});
    for (cyc = 0; cyc < 100 && sreset_o; cyc++) #50;
    chk("reset ended", 1'b0, sreset_o);
    #100;
    chk("rolloff", 1'b0, roll_o);
    chk("format", 4'h5, form_o);
    chk("codes", {8{8'hFF}}, code_o);
    chk("mode", 17'h0, {mode_o, mute_o, dis_o});
    $display("soft reset test done");
    end_sim;
  end
endmodule
`default_nettype wire
